// ---- dv/bcbd_regs_model.sv ----
// Register-file model standing for the execute pipeline.
// Assumes the bench presents each instruction word on insn_word.
`default_nettype none

module bcbd_regs_model (
    input  wire logic [15:0] insn_word,
    output var  logic [7:0]  bitno_reg_value
);
    timeunit 1ns;
    timeprecision 1ns;
    // Register n holds n in both nibbles, so register n gives bit number n modulo 8 (registers 0-7 give their own).
    always_comb begin
        bitno_reg_value = {2{insn_word[7:4]}};
    end
endmodule : bcbd_regs_model

`default_nettype wire

// ---- dv/test_bcbd_core.sv ----
// Self-checking bench for the branch and bit-operation decoder.
// Assumes the register-file model answers bit numbers combinationally.
`default_nettype none

module test_bcbd_core
    import bcbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst, flag_c, flag_z, flag_v, flag_n, branch_valid, call_valid;
    logic ret_valid, bitop_valid, bitno_from_reg, branch_taken, pc_load, result_valid;
    logic illegal_form, result_write, carry_out, carry_write, zero_out, zero_write;
    logic [3:0]  cond_sel, operand_reg, bitno_reg;
    logic [15:0] target_addr, cur_pc, insn_word, pc_next_value;
    logic [7:0]  bitno_reg_value, operand_value, bit_opcode, abs_addr, result_value;
    bcbd_bitop_t bitop_sel;
    bcbd_form_t  bitop_form;
    int          err_total, n_compared, cyc;

    bcbd_core u_dut (.*);
    bcbd_regs_model u_regs (.insn_word(insn_word), .bitno_reg_value(bitno_reg_value));

    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            test_done();
        end
    end

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic test_done();
        $display("compared=%0d errors=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // Taken-or-not of each pair is the base value, flipped by the low selector bit.
    function automatic logic cnd(input logic [3:0] s, input logic [3:0] f);
        logic x;
        x = f[1] ^ f[0];
        case (s[3:1])
            3'h0: return 1'b1 ^ s[0];
            3'h1: return !(f[3] | f[2]) ^ s[0];
            3'h2: return !f[3] ^ s[0];
            3'h3: return !f[2] ^ s[0];
            3'h4: return !f[1] ^ s[0];
            3'h5: return !f[0] ^ s[0];
            3'h6: return !x ^ s[0];
            default: return !(f[2] | x) ^ s[0];
        endcase
    endfunction : cnd

    task automatic t_cond();
        for (int s = 0; s < 16; s++) begin
            for (int f = 0; f < 16; f++) begin
                {flag_c, flag_z, flag_v, flag_n} = f[3:0];
                cond_sel = s[3:0];
                branch_valid = 1;
                target_addr = {8'h12, s[3:0], f[3:0]};
                @(negedge core_clk);
                chk(branch_taken, cnd(s[3:0], f[3:0]));
                chk(pc_load, cnd(s[3:0], f[3:0]));
                if (cnd(s[3:0], f[3:0]))
                    chk(pc_next_value, {8'h12, s[3:0], f[3:0]});
            end
        end
        branch_valid = 0;
    endtask : t_cond

    task automatic cr(input logic c, input logic [15:0] pc, tg, ex);
        call_valid = c;
        ret_valid = !c;
        cur_pc = pc;
        target_addr = tg;
        @(negedge core_clk);
        chk(pc_load, 1);
        chk(pc_next_value, ex);
        call_valid = 0;
        ret_valid = 0;
        @(negedge core_clk);
    endtask : cr

    task automatic t_call();
        cr(1, 16'h4000, 16'h5000, 16'h5000);
        cr(1, 16'h5010, 16'h6000, 16'h6000);
        cr(0, 16'h6004, 16'h0000, 16'h5012);
        cr(0, 16'h5014, 16'h0000, 16'h4002);
        // Back-to-back call and return: the return pops the word pushed a cycle earlier.
        call_valid = 1;
        cur_pc = 16'h7000;
        target_addr = 16'h7100;
        @(negedge core_clk);
        chk(pc_next_value, 16'h7100);
        call_valid = 0;
        ret_valid = 1;
        @(negedge core_clk);
        chk(pc_next_value, 16'h7002);
        ret_valid = 0;
        @(negedge core_clk);
    endtask : t_call

    task automatic bw(input logic [3:0] op, input logic [1:0] fm, input logic fr,
                      input logic [15:0] w, input logic [7:0] v);
        bitop_valid = 1;
        bitop_sel = bcbd_bitop_t'(op);
        bitop_form = bcbd_form_t'(fm);
        bitno_from_reg = fr;
        insn_word = w;
        operand_value = v;
        @(negedge core_clk);
    endtask : bw

    task automatic t_bits();
        logic [7:0] ec;
        ec = 8'b1011_0110;
        flag_c = 1;
        bw(4'h0, 2'h0, 0, 16'h7053, 8'h00);
        chk(result_value, 8'h20);
        chk({bit_opcode, operand_reg}, 12'h703);
        bw(4'h1, 2'h0, 1, 16'h6294, 8'hff);
        chk(result_value, 8'hfd);
        chk(bitno_reg, 4'h9);
        bw(4'h3, 2'h0, 0, 16'h7321, 8'h04);
        chk({zero_write, zero_out, result_write}, 3'b100);
        bw(4'h3, 2'h0, 0, 16'h7321, 8'hfb);
        chk({zero_write, zero_out}, 2'b11);
        bw(4'h3, 2'h0, 1, 16'h7350, 8'h20);
        chk({zero_write, zero_out}, 2'b10);
        bw(4'h2, 2'h0, 0, 16'h7040, 8'h0f);
        chk({result_write, result_value}, 9'h11f);
        bw(4'h8, 2'h0, 0, 16'h7070, 8'h00);
        chk(result_value, 8'h80);
        for (int i = 0; i < 8; i++) begin
            bw((i < 4) ? 4'(4 + i) : 4'(5 + i), 2'h0, 0, 16'h7602, 8'h00);
            chk({carry_write, carry_out}, {1'b1, ec[i]});
        end
        bw(4'hd, 2'h0, 0, 16'h6722, 8'hff);
        chk(result_value, 8'hfb);
        bw(4'h9, 2'h0, 1, 16'h7622, 8'h00);
        chk({illegal_form, carry_write}, 2'b10);
        bw(4'h0, 2'h2, 0, 16'h7e5a, 8'h00);
        chk(result_valid, 1'b0);
        bw(4'h0, 2'h2, 0, 16'h7060, 8'h01);
        chk({abs_addr, result_value}, 16'h5a41);
        chk(result_valid, 1'b1);
        bw(4'h0, 2'h1, 0, 16'h7c30, 8'h00);
        chk({result_valid, operand_reg}, 5'h03);
        bw(4'h0, 2'h1, 0, 16'h7015, 8'h00);
        chk({illegal_form, result_write}, 2'b10);
        bitop_valid = 0;
    endtask : t_bits

    initial begin
        {rst, flag_c, flag_z, flag_v, flag_n, branch_valid, call_valid} = 7'h40;
        {ret_valid, bitop_valid, bitno_from_reg, cond_sel} = 7'h00;
        {target_addr, cur_pc, insn_word, operand_value} = 56'h0;
        bitop_sel = BCBD_OP_SET;
        bitop_form = BCBD_FORM_REG;
        repeat (8) @(negedge core_clk);
        rst = 0;
        chk({pc_load, result_valid}, 2'b00);
        t_cond();
        t_call();
        t_bits();
        test_done();
    end
endmodule : test_bcbd_core

`default_nettype wire

// ---- rtl/bcbd_core.sv ----
// Branch-condition evaluator, call/return sequencer and bit-operation decoder.
// Assumes instruction words come from the fetch logic on the same clock.
`default_nettype none

// Notes on behaviour
// - A branch loads the target only if its condition holds; always takes, never skips.
// - Equal/not-equal test Z, overflow pairs test V, plus/minus test N.
// - Higher needs C and Z clear, lower-or-same either set; carry pair tests C.
// - Signed ge/lt use N xor V; gt/le use Z or (N xor V).
// - Calls jump to the target and returns resume after the call.
// - Register bit ops take opcode from 15:8, bit number from 7:4, register from 3:0.
// - Memory bit ops take two words: pointer or address, then bit number, low nibble 0.
// - Inverted-operand ops accept only an immediate bit number.
// - The bit number selects one of eight positions from the immediate or register low bits.
// - The test op sets Z to the inverse of the selected bit and keeps the operand.
// - Carry ops AND, OR or XOR carry with the bit or its inverse into carry.

module bcbd_core
    import bcbd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        flag_c,
    input  wire logic        flag_z,
    input  wire logic        flag_v,
    input  wire logic        flag_n,
    input  wire logic [3:0]  cond_sel,
    input  wire logic        branch_valid,
    input  wire logic        call_valid,
    input  wire logic        ret_valid,
    input  wire logic [15:0] target_addr,
    input  wire logic [15:0] cur_pc,
    input  wire logic        bitop_valid,
    input  wire logic [15:0] insn_word,
    input  wire bcbd_bitop_t bitop_sel,
    input  wire bcbd_form_t  bitop_form,
    input  wire logic        bitno_from_reg,
    input  wire logic [7:0]  bitno_reg_value,
    input  wire logic [7:0]  operand_value,
    output var  logic        branch_taken,
    output var  logic        pc_load,
    output var  logic [15:0] pc_next_value,
    output var  logic [7:0]  bit_opcode,
    output var  logic [3:0]  operand_reg,
    output var  logic [3:0]  bitno_reg,
    output var  logic [7:0]  abs_addr,
    output var  logic        result_valid,
    output var  logic        illegal_form,
    output var  logic [7:0]  result_value,
    output var  logic        result_write,
    output var  logic        carry_out,
    output var  logic        carry_write,
    output var  logic        zero_out,
    output var  logic        zero_write
);

    // ------------------------------------------------------------------
    // Condition evaluation
    // ------------------------------------------------------------------
    function automatic logic bcbd_cond(input logic [3:0] sel, input logic c,
                                       input logic z, input logic v, input logic n);
        logic r;
        r = 1'b0;
        case (sel)
            BCBD_CC_ALWAYS: r = 1'b1;
            BCBD_CC_NEVER:  r = 1'b0;
            BCBD_CC_HI:     r = ~(c | z);
            BCBD_CC_LS:     r = c | z;
            BCBD_CC_CC:     r = ~c;
            BCBD_CC_CS:     r = c;
            BCBD_CC_NE:     r = ~z;
            BCBD_CC_EQ:     r = z;
            BCBD_CC_VC:     r = ~v;
            BCBD_CC_VS:     r = v;
            BCBD_CC_PL:     r = ~n;
            BCBD_CC_MI:     r = n;
            BCBD_CC_GE:     r = ~(n ^ v);
            BCBD_CC_LT:     r = n ^ v;
            BCBD_CC_GT:     r = ~(z | (n ^ v));
            BCBD_CC_LE:     r = z | (n ^ v);
            default:        r = 1'b0;
        endcase
        return r;
    endfunction : bcbd_cond

    logic cond_now;
    assign cond_now = bcbd_cond(cond_sel, flag_c, flag_z, flag_v, flag_n);

    // ------------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------------
    logic [15:0] ret_addr;

    bcbd_stack #(
        .DEPTH (8)
    ) u_stack (
        .core_clk  (core_clk),
        .rst       (rst),
        .push      (call_valid),
        .pop       (ret_valid & ~call_valid),
        .push_data (cur_pc + BCBD_INSN_LEN),
        .top_data  (ret_addr)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        bcbd_state_t st;
        bcbd_bitop_t op;
        bcbd_form_t  form;
        logic        from_reg;
        logic        branch_taken;
        logic        pc_load;
        logic [15:0] pc_next_value;
        logic [7:0]  bit_opcode;
        logic [3:0]  operand_reg;
        logic [3:0]  bitno_reg;
        logic [7:0]  abs_addr;
        logic        result_valid;
        logic        illegal_form;
        logic [7:0]  result_value;
        logic        result_write;
        logic        carry_out;
        logic        carry_write;
        logic        zero_out;
        logic        zero_write;
    } bcbd_core_state_t;

    bcbd_core_state_t s_reg;
    bcbd_core_state_t s_next;

    function automatic logic bcbd_inverted(input bcbd_bitop_t op);
        return op inside {BCBD_OP_IAND, BCBD_OP_IOR, BCBD_OP_IXOR, BCBD_OP_ILD, BCBD_OP_IST};
    endfunction : bcbd_inverted

    logic [2:0] bit_idx;
    logic       sel_bit;
    logic       opnd_bit;
    logic       first_ok;

    always_comb begin
        s_next              = s_reg;
        s_next.pc_load      = 1'b0;
        s_next.result_valid = 1'b0;
        s_next.result_write = 1'b0;
        s_next.carry_write  = 1'b0;
        s_next.zero_write   = 1'b0;
        s_next.illegal_form = 1'b0;
        s_next.branch_taken = cond_now;
        bit_idx  = '0;
        sel_bit  = 1'b0;
        opnd_bit = 1'b0;
        first_ok = 1'b1;

        // Control flow: call has priority over return, return over branch.
        if (call_valid) begin
            s_next.pc_load       = 1'b1;
            s_next.pc_next_value = target_addr;
        end else if (ret_valid) begin
            s_next.pc_load       = 1'b1;
            s_next.pc_next_value = ret_addr;
        end else if (branch_valid && cond_now) begin
            s_next.pc_load       = 1'b1;
            s_next.pc_next_value = target_addr;
        end

        case (s_reg.st)
            BCBD_ST_IDLE: begin
                if (bitop_valid) begin
                    s_next.bit_opcode = insn_word[BCBD_OPC_MSB:BCBD_OPC_LSB];
                    s_next.op         = bitop_sel;
                    s_next.form       = bitop_form;
                    s_next.from_reg   = bitno_from_reg;
                    // Register-supplied bit number only for set/clear/invert/test.
                    first_ok = !(bitno_from_reg && !(bitop_sel inside
                        {BCBD_OP_SET, BCBD_OP_CLR, BCBD_OP_NOT, BCBD_OP_TST}));
                    if (bcbd_inverted(bitop_sel) && bitno_from_reg) begin
                        first_ok = 1'b0;
                    end
                    if (!first_ok) begin
                        s_next.illegal_form = 1'b1;
                        s_next.result_valid = 1'b1;
                    end else if (bitop_form == BCBD_FORM_REG) begin
                        s_next.operand_reg = insn_word[BCBD_LO_MSB:BCBD_LO_LSB];
                        s_next.bitno_reg   = insn_word[BCBD_HI_MSB:BCBD_HI_LSB];
                        bit_idx = bitno_from_reg ? bitno_reg_value[2:0]
                                                 : insn_word[6:4];
                        s_next.result_valid = 1'b1;
                    end else begin
                        // First of two words: pointer register or 8-bit address.
                        s_next.operand_reg = insn_word[BCBD_HI_MSB:BCBD_HI_LSB];
                        s_next.abs_addr    = insn_word[7:0];
                        s_next.st          = BCBD_ST_EXT;
                    end
                end
            end
            BCBD_ST_EXT: begin
                if (bitop_valid) begin
                    s_next.st         = BCBD_ST_IDLE;
                    s_next.bitno_reg  = insn_word[BCBD_HI_MSB:BCBD_HI_LSB];
                    bit_idx = s_reg.from_reg ? bitno_reg_value[2:0]
                                             : insn_word[6:4];
                    s_next.illegal_form = (insn_word[BCBD_LO_MSB:BCBD_LO_LSB] != 4'h0);
                    s_next.result_valid = 1'b1;
                end
            end
            default: s_next.st = BCBD_ST_IDLE;
        endcase

        opnd_bit = operand_value[bit_idx];
        if (s_next.result_valid && !s_next.illegal_form) begin
            sel_bit = bcbd_inverted(s_next.op) ? ~opnd_bit : opnd_bit;
            s_next.result_value = operand_value;
            case (s_next.op)
                BCBD_OP_SET: begin
                    s_next.result_value[bit_idx] = 1'b1;
                    s_next.result_write = 1'b1;
                end
                BCBD_OP_CLR: begin
                    s_next.result_value[bit_idx] = 1'b0;
                    s_next.result_write = 1'b1;
                end
                BCBD_OP_NOT: begin
                    s_next.result_value[bit_idx] = ~opnd_bit;
                    s_next.result_write = 1'b1;
                end
                BCBD_OP_TST: begin
                    s_next.zero_out   = ~opnd_bit;
                    s_next.zero_write = 1'b1;
                end
                BCBD_OP_AND, BCBD_OP_IAND: begin
                    s_next.carry_out   = flag_c & sel_bit;
                    s_next.carry_write = 1'b1;
                end
                BCBD_OP_OR, BCBD_OP_IOR: begin
                    s_next.carry_out   = flag_c | sel_bit;
                    s_next.carry_write = 1'b1;
                end
                BCBD_OP_XOR, BCBD_OP_IXOR: begin
                    s_next.carry_out   = flag_c ^ sel_bit;
                    s_next.carry_write = 1'b1;
                end
                BCBD_OP_LD, BCBD_OP_ILD: begin
                    s_next.carry_out   = sel_bit;
                    s_next.carry_write = 1'b1;
                end
                BCBD_OP_ST: begin
                    s_next.result_value[bit_idx] = flag_c;
                    s_next.result_write = 1'b1;
                end
                BCBD_OP_IST: begin
                    s_next.result_value[bit_idx] = ~flag_c;
                    s_next.result_write = 1'b1;
                end
                default: s_next.result_write = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_reg               <= '0;
            s_reg.st            <= BCBD_ST_IDLE;
            s_reg.op            <= BCBD_OP_SET;
            s_reg.form          <= BCBD_FORM_REG;
            s_reg.pc_next_value <= BCBD_RST_PC;
            s_reg.result_value  <= BCBD_RST_BYTE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign branch_taken  = s_reg.branch_taken;
    assign pc_load       = s_reg.pc_load;
    assign pc_next_value = s_reg.pc_next_value;
    assign bit_opcode    = s_reg.bit_opcode;
    assign operand_reg   = s_reg.operand_reg;
    assign bitno_reg     = s_reg.bitno_reg;
    assign abs_addr      = s_reg.abs_addr;
    assign result_valid  = s_reg.result_valid;
    assign illegal_form  = s_reg.illegal_form;
    assign result_value  = s_reg.result_value;
    assign result_write  = s_reg.result_write;
    assign carry_out     = s_reg.carry_out;
    assign carry_write   = s_reg.carry_write;
    assign zero_out      = s_reg.zero_out;
    assign zero_write    = s_reg.zero_write;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence taken_branch_s;
        branch_valid && !call_valid && !ret_valid && cond_now;
    endsequence

    // A call followed at once by a return, so the return pops the word just pushed.
    sequence call_then_ret_s;
        call_valid ##1 (!call_valid && ret_valid);
    endsequence

    branch_load_a: assert property (
        taken_branch_s |=> pc_load && pc_next_value == $past(target_addr))
        else $error("taken branch did not load target");
    branch_skip_a: assert property (
        branch_valid && !call_valid && !ret_valid && !cond_now |=> !pc_load)
        else $error("untaken branch loaded pc");
    eq_cond_a: assert property (cond_sel == BCBD_CC_EQ |-> cond_now == flag_z)
        else $error("equal condition wrong");
    hi_cond_a: assert property (
        cond_sel == BCBD_CC_HI |-> cond_now == !(flag_c || flag_z))
        else $error("higher condition wrong");
    gt_cond_a: assert property (
        cond_sel == BCBD_CC_GT |-> cond_now == !(flag_z || (flag_n != flag_v)))
        else $error("signed greater condition wrong");
    call_ret_a: assert property (
        call_then_ret_s |=> pc_next_value == $past(cur_pc, 2) + BCBD_INSN_LEN)
        else $error("return address wrong");
    reg_fields_a: assert property (
        s_reg.st == BCBD_ST_IDLE && bitop_valid && bitop_form == BCBD_FORM_REG
        |=> bit_opcode == $past(insn_word[15:8]) && operand_reg == $past(insn_word[3:0]))
        else $error("register form fields wrong");
    inv_imm_a: assert property (
        s_reg.st == BCBD_ST_IDLE && bitop_valid && bcbd_inverted(bitop_sel) && bitno_from_reg
        |=> illegal_form)
        else $error("inverted op accepted register bit number");
    two_word_a: assert property (
        s_reg.st == BCBD_ST_IDLE && bitop_valid && bitop_form != BCBD_FORM_REG
        && !bitno_from_reg |=> !result_valid)
        else $error("memory form finished in one word");
    test_zero_a: assert property (result_valid && zero_write |-> !result_write)
        else $error("test op wrote operand");
    carry_and_a: assert property (
        s_reg.st == BCBD_ST_IDLE && bitop_valid && bitop_form == BCBD_FORM_REG
        && !bitno_from_reg && bitop_sel == BCBD_OP_AND
        |=> carry_write && carry_out == ($past(flag_c) & $past(operand_value[insn_word[6:4]])))
        else $error("carry and wrong");
    reg_bitno_a: assert property (
        s_reg.st == BCBD_ST_IDLE && bitop_valid && bitop_form == BCBD_FORM_REG
        && bitno_from_reg && bitop_sel == BCBD_OP_TST
        |=> zero_out == !$past(operand_value[bitno_reg_value[2:0]]))
        else $error("register bit number test wrong");

endmodule : bcbd_core

`default_nettype wire

// ---- rtl/bcbd_pkg.sv ----
// Package for the branch-condition and bit-operation decoder.
// Assumes a single 100 MHz core clock and a synchronous active-high reset.
`default_nettype none

package bcbd_pkg;

    // ------------------------------------------------------------------
    // Condition selector codes
    // ------------------------------------------------------------------
    localparam logic [3:0] BCBD_CC_ALWAYS = 4'h0;
    localparam logic [3:0] BCBD_CC_NEVER  = 4'h1;
    localparam logic [3:0] BCBD_CC_HI     = 4'h2;
    localparam logic [3:0] BCBD_CC_LS     = 4'h3;
    localparam logic [3:0] BCBD_CC_CC     = 4'h4;
    localparam logic [3:0] BCBD_CC_CS     = 4'h5;
    localparam logic [3:0] BCBD_CC_NE     = 4'h6;
    localparam logic [3:0] BCBD_CC_EQ     = 4'h7;
    localparam logic [3:0] BCBD_CC_VC     = 4'h8;
    localparam logic [3:0] BCBD_CC_VS     = 4'h9;
    localparam logic [3:0] BCBD_CC_PL     = 4'ha;
    localparam logic [3:0] BCBD_CC_MI     = 4'hb;
    localparam logic [3:0] BCBD_CC_GE     = 4'hc;
    localparam logic [3:0] BCBD_CC_LT     = 4'hd;
    localparam logic [3:0] BCBD_CC_GT     = 4'he;
    localparam logic [3:0] BCBD_CC_LE     = 4'hf;

    // ------------------------------------------------------------------
    // Bit operation codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        BCBD_OP_SET   = 4'h0,
        BCBD_OP_CLR   = 4'h1,
        BCBD_OP_NOT   = 4'h2,
        BCBD_OP_TST   = 4'h3,
        BCBD_OP_AND   = 4'h4,
        BCBD_OP_OR    = 4'h5,
        BCBD_OP_XOR   = 4'h6,
        BCBD_OP_LD    = 4'h7,
        BCBD_OP_ST    = 4'h8,
        BCBD_OP_IAND  = 4'h9,
        BCBD_OP_IOR   = 4'ha,
        BCBD_OP_IXOR  = 4'hb,
        BCBD_OP_ILD   = 4'hc,
        BCBD_OP_IST   = 4'hd
    } bcbd_bitop_t;

    // Operand forms.
    typedef enum logic [1:0] {
        BCBD_FORM_REG = 2'h0,
        BCBD_FORM_IND = 2'h1,
        BCBD_FORM_ABS = 2'h2
    } bcbd_form_t;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         BCBD_OPC_MSB   = 15;
    localparam int         BCBD_OPC_LSB   = 8;
    localparam int         BCBD_HI_MSB    = 7;
    localparam int         BCBD_HI_LSB    = 4;
    localparam int         BCBD_LO_MSB    = 3;
    localparam int         BCBD_LO_LSB    = 0;
    localparam logic [7:0] BCBD_RST_BYTE  = 8'h00;
    localparam logic [15:0] BCBD_RST_PC   = 16'h0000;
    localparam logic [15:0] BCBD_INSN_LEN = 16'h0002;

    typedef enum logic [1:0] {
        BCBD_ST_IDLE = 2'b01,
        BCBD_ST_EXT  = 2'b10
    } bcbd_state_t;

endpackage : bcbd_pkg

`default_nettype wire

// ---- rtl/bcbd_stack.sv ----
// Small return-address stack for subroutine calls.
// Assumes push and pop never arrive together and depth is not exceeded.
`default_nettype none

module bcbd_stack
    import bcbd_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        push,
    input  wire logic        pop,
    input  wire logic [15:0] push_data,
    output var  logic [15:0] top_data
);

    logic [15:0]              mem_reg [DEPTH];
    logic [$clog2(DEPTH)-1:0] sp_reg;

    // ------------------------------------------------------------------
    // Storage with registered top word.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sp_reg   <= '0;
            top_data <= BCBD_RST_PC;
        end else if (push) begin
            mem_reg[sp_reg] <= push_data;
            sp_reg          <= sp_reg + 1'b1;
            top_data        <= push_data;
        end else if (pop) begin
            sp_reg   <= sp_reg - 1'b1;
            top_data <= mem_reg[sp_reg - 2'd2];
        end
    end

endmodule : bcbd_stack

`default_nettype wire
